// File: dv/frm_core_chk.sv
// Port-level assertions for the floppy reset, motor and media core
`timescale 1ns/1ps
module frm_core_chk (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic master_reset_in_i,
   input wire logic [1:0] media_sense_in_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [1:0] motor_enable_n_o,
   input wire logic [1:0] media_present_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("request not acknowledged on the next edge");
   AST_ACK_ONE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without a request");
   AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   AST_RST_QUIET: assert property (disable iff (1'b0) !rst_b_i && ce_i |=>
      !wb_ack_o && motor_enable_n_o == 2'b11 && media_present_o == 2'b00)
      else $error("outputs not quiet after system reset");
   AST_MR_MOTOR: assert property ((master_reset_in_i && ce_i)[*4] |=> motor_enable_n_o == 2'b11)
      else $error("motor line active under master reset");
   AST_MR_MEDIA: assert property ((master_reset_in_i && ce_i)[*6] |=> media_present_o == 2'b00)
      else $error("media sense still enabled under master reset");
   AST_MOTOR_CAUSE: assert property ($changed(motor_enable_n_o) |->
      $past(wb_ack_o) || $past(master_reset_in_i, 2) || $past(master_reset_in_i, 3))
      else $error("motor lines changed without a write or master reset");
   AST_MEDIA_SRC: assert property (media_present_o != 2'b00 |-> (media_present_o &
      ~($past(media_sense_in_i, 2) | $past(media_sense_in_i, 3))) == 2'b00)
      else $error("media present without a sensed pin");
endmodule
bind frm_core frm_core_chk frm_core_chk_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
   .master_reset_in_i(master_reset_in_i), .media_sense_in_i(media_sense_in_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motor_enable_n_o(motor_enable_n_o),
   .media_present_o(media_present_o));

// File: dv/frm_drive_model.sv
// Model of the two floppy drives on the disk interface
`timescale 1ns/1ps
module frm_drive_model (
   input wire logic [1:0] motor_enable_n_i,
   input wire logic [1:0] attached_i,
   input wire logic [1:0] media_i,
   output logic [1:0] media_sense_o,
   output logic [1:0] spinning_o
);
   // An absent drive leaves its sense line to the pull-up, so it reads high
   assign media_sense_o = (attached_i & media_i) | ~attached_i;
   assign spinning_o = ~motor_enable_n_i & attached_i;
endmodule

// File: dv/tb.sv
// Self-checking testbench for the floppy reset, motor and media core
`timescale 1ns/1ps
module tb;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic mr = 1'b0;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] q;
   logic wb_ack;
   logic [1:0] motor_n;
   logic [1:0] present;
   logic [1:0] sense;
   logic [1:0] attached = 2'b00;
   logic [1:0] media = 2'b00;
   logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'hF0};
   int error_cnt = 0;
   int n_tests = 0;
   int cyc_cnt = 0;

   always #2 clock_i = ~clock_i;

   frm_core frm_core_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce), .master_reset_in_i(mr),
      .media_sense_in_i(sense), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack),
      .motor_enable_n_o(motor_n), .media_present_o(present));
   frm_drive_model frm_drive_model_inst (.motor_enable_n_i(motor_n), .attached_i(attached),
      .media_i(media), .media_sense_o(sense), .spinning_o());

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Timeout
   // ----------------------------------------------------------------
   always @(posedge clock_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One classic cycle; ack is read before this edge's updates land
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      sel <= s;
      do @(posedge clock_i); while (wb_ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'h1);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00, 4'hF);
      chk(name, q, {24'h00_0000, e});
   endtask

   task automatic regs_chk(input logic [7:0] tval);
      for (int i = 0; i < 8; i++) begin
         rd_chk("register", regs[i], (i == 6) ? tval : 8'h00);
      end
   endtask

   task automatic mt(input logic [7:0] d, input logic [1:0] e);
      wr(8'h00, d);
      @(posedge clock_i);
      chk("motor", 32'(motor_n), 32'(e));
   endtask

   task automatic md(input logic [1:0] e);
      repeat (6) @(posedge clock_i);
      chk("media", 32'(present), 32'(e));
   endtask

   initial begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      regs_chk(8'h00);
      rd_chk("unmapped", 8'h30, 8'h00);
      chk("motor", 32'(motor_n), 32'h0000_0003);
      $display("test reset done");
      mt(8'h10, 2'b10);
      mt(8'h20, 2'b01);
      mt(8'h30, 2'b00);
      mt(8'hC0, 2'b11);
      wr(8'hF0, 8'h80);
      mt(8'h42, 2'b00);
      mt(8'h41, 2'b11);
      mt(8'h21, 2'b10);
      mt(8'h83, 2'b00);
      mt(8'h12, 2'b11);
      wr(8'hF0, 8'h00);
      bus(8'h04, 1'b1, 8'h55, 4'hE);
      rd_chk("lane", 8'h04, 8'h00);
      $display("test motor done");
      attached <= 2'b01;
      md(2'b00);
      wr(8'hF0, 8'h40);
      md(2'b10);
      media <= 2'b01;
      md(2'b11);
      wr(8'hF0, 8'h00);
      md(2'b00);
      attached <= 2'b00;
      $display("test media done");
      wr(8'h1C, 8'h5A);
      wr(8'h10, 8'h33);
      wr(8'h14, 8'h44);
      wr(8'h18, 8'h01);
      wr(8'h00, 8'h30);
      wr(8'h04, 8'h02);
      wr(8'h08, 8'h01);
      wr(8'hF0, 8'hC0);
      ce <= 1'b0;
      mr <= 1'b1;
      repeat (6) @(posedge clock_i);
      mr <= 1'b0;
      repeat (3) @(posedge clock_i);
      ce <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk("motor frozen", 32'(motor_n), 32'h0000_0002);
      rd_chk("frozen", 8'h00, 8'h30);
      wr(8'h20, 8'h01);
      rd_chk("status", 8'h0C, 8'h0D);
      mr <= 1'b1;
      repeat (4) @(posedge clock_i);
      wr(8'h00, 8'h30);
      rd_chk("status", 8'h0C, 8'h02);
      chk("motor", 32'(motor_n), 32'h0000_0003);
      mr <= 1'b0;
      repeat (4) @(posedge clock_i);
      regs_chk(8'h5A);
      wr(8'h20, 8'h01);
      rd_chk("status", 8'h0C, 8'h01);
      repeat (frm_pkg::CMD_CYCLES + 4) @(posedge clock_i);
      rd_chk("status", 8'h0C, 8'h00);
      $display("test master reset done");
      test_done();
   end
endmodule

// File: src/frm_core.sv
// Floppy reset, motor enable and media sense core with a classic Wishbone register slave
//
// Contract
// - While master reset is high the command sequencer is returned to idle.
// - Master reset drives every output toward the drives to its inactive level.
// - Master reset clears the drive output, data rate and config control registers to zero.
// - Master reset restores the mode, setup and lock command parameters to their defaults.
// - Master reset leaves the drive timing parameters untouched.
// - Master reset loads the floppy configuration register with its default.
// - The two motor lines for drives 0 and 1 follow bits 4 and 5 of the drive output register.
// - A motor line is active when low and inactive when high.
// - With the four-drive bit set, the two motor lines carry a four-drive encoding.
// - Media sense inputs count only while the media sense enable bit of the floppy config is 1.
`timescale 1ns/1ps
module frm_core #(
   parameter int CMD_CYCLES = frm_pkg::CMD_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic master_reset_in_i,
   input wire logic [1:0] media_sense_in_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [1:0] motor_enable_n_o,
   output logic [1:0] media_present_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (CMD_CYCLES < 1 || CMD_CYCLES > 255) begin : g_bad_cycles
         $error("frm_core: CMD_CYCLES must lie in 1..255");
      end
      if (frm_pkg::CFG_MEDIA_EN_BIT > 7 || frm_pkg::CFG_FOUR_DRIVE_BIT > 7) begin : g_bad_cfg_bits
         $error("frm_core: floppy config bits must lie inside the byte");
      end
      if (frm_pkg::MOTOR_LSB + 4 > 8 || frm_pkg::DRV_SEL_LSB + 2 > 8) begin : g_bad_drive_fields
         $error("frm_core: drive output fields must lie inside the byte");
      end
      if (frm_pkg::STAT_MEDIA_LSB + 2 > 8) begin : g_bad_stat_fields
         $error("frm_core: status fields must lie inside the byte");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic mr_meta_r;
   logic mr_sync_r;
   logic [1:0] ms_meta_r;
   logic [1:0] ms_sync_r;

   // Pins come from outside the clock domain; only the second stage is read
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         mr_meta_r <= 1'b0;
         mr_sync_r <= 1'b0;
         ms_meta_r <= 2'h0;
         ms_sync_r <= 2'h0;
      end else if (ce_i) begin
         mr_meta_r <= master_reset_in_i;
         mr_sync_r <= mr_meta_r;
         ms_meta_r <= media_sense_in_i;
         ms_sync_r <= ms_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A request still held after its ack is taken again, so a master must drop stb after ack
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes under master reset are acked but dropped, so the bus never stalls
   wire bus_wr = bus_req & wb_we_i & wb_sel_i[0] & ~mr_sync_r;
   wire bus_rd = bus_req & ~wb_we_i;
   wire [7:0] wr_byte = wb_dat_i[7:0];

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
      hit = (adr == reg_adr);
   endfunction

   wire sel_drive_out = hit(wb_adr_i, frm_pkg::ADDR_DRIVE_OUT);
   wire sel_data_rate = hit(wb_adr_i, frm_pkg::ADDR_DATA_RATE);
   wire sel_cfg_ctrl = hit(wb_adr_i, frm_pkg::ADDR_CFG_CTRL);
   wire sel_status = hit(wb_adr_i, frm_pkg::ADDR_STATUS);
   wire sel_mode = hit(wb_adr_i, frm_pkg::ADDR_MODE_PARAM);
   wire sel_setup = hit(wb_adr_i, frm_pkg::ADDR_SETUP_PARAM);
   wire sel_lock = hit(wb_adr_i, frm_pkg::ADDR_LOCK_PARAM);
   wire sel_timing = hit(wb_adr_i, frm_pkg::ADDR_TIMING_PARAM);
   wire sel_command = hit(wb_adr_i, frm_pkg::ADDR_COMMAND);
   wire sel_fcfg = hit(wb_adr_i, frm_pkg::ADDR_FLOPPY_CONFIG);
   wire cmd_start = bus_wr & sel_command;

   // ----------------------------------------------------------------
   // Registers; all but drive timing are cleared or defaulted by master reset
   // ----------------------------------------------------------------
   logic [7:0] drive_output_control_reg_r;
   logic [7:0] data_rate_r;
   logic [7:0] config_control_reg_r;
   logic [7:0] mode_param_r;
   logic [7:0] setup_param_r;
   logic [7:0] lock_param_r;
   logic [7:0] floppy_config_r;
   logic [7:0] timing_param_r;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         drive_output_control_reg_r <= frm_pkg::RST_ZERO;
         data_rate_r <= frm_pkg::RST_ZERO;
         config_control_reg_r <= frm_pkg::RST_ZERO;
      end else if (ce_i) begin
         if (mr_sync_r) begin
            drive_output_control_reg_r <= frm_pkg::RST_ZERO;
            data_rate_r <= frm_pkg::RST_ZERO;
            config_control_reg_r <= frm_pkg::RST_ZERO;
         end else if (bus_wr) begin
            if (sel_drive_out) begin
               drive_output_control_reg_r <= wr_byte;
            end
            if (sel_data_rate) begin
               data_rate_r <= wr_byte;
            end
            if (sel_cfg_ctrl) begin
               config_control_reg_r <= wr_byte;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         mode_param_r <= frm_pkg::RST_MODE_PARAM;
         setup_param_r <= frm_pkg::RST_SETUP_PARAM;
         lock_param_r <= frm_pkg::RST_LOCK_PARAM;
         floppy_config_r <= frm_pkg::RST_FLOPPY_CONFIG;
      end else if (ce_i) begin
         if (mr_sync_r) begin
            mode_param_r <= frm_pkg::RST_MODE_PARAM;
            setup_param_r <= frm_pkg::RST_SETUP_PARAM;
            lock_param_r <= frm_pkg::RST_LOCK_PARAM;
            floppy_config_r <= frm_pkg::RST_FLOPPY_CONFIG;
         end else if (bus_wr) begin
            if (sel_mode) begin
               mode_param_r <= wr_byte;
            end
            if (sel_setup) begin
               setup_param_r <= wr_byte;
            end
            if (sel_lock) begin
               lock_param_r <= wr_byte;
            end
            if (sel_fcfg) begin
               floppy_config_r <= wr_byte;
            end
         end
      end
   end

   // Drive timing survives master reset; only the system reset defaults it
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         timing_param_r <= frm_pkg::RST_TIMING_PARAM;
      end else if (ce_i && bus_wr && sel_timing) begin
         timing_param_r <= wr_byte;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   frm_pkg::frm_seq_t seq_r;
   frm_pkg::frm_seq_t seq_nxt;
   logic [7:0] seq_cnt_r;
   logic [7:0] seq_cnt_nxt;
   // A command written while busy is ignored; software polls the busy bit first
   localparam logic [7:0] CMD_LAST = 8'(CMD_CYCLES - 1);

   always_comb begin
      seq_nxt = seq_r;
      seq_cnt_nxt = seq_cnt_r;
      case (seq_r)
         frm_pkg::SEQ_IDLE: begin
            if (cmd_start) begin
               seq_nxt = frm_pkg::SEQ_BUSY;
               seq_cnt_nxt = 8'h00;
            end
         end
         frm_pkg::SEQ_BUSY: begin
            if (seq_cnt_r == CMD_LAST) begin
               seq_nxt = frm_pkg::SEQ_IDLE;
            end else begin
               seq_cnt_nxt = seq_cnt_r + 8'h01;
            end
         end
         default: begin
            seq_nxt = frm_pkg::SEQ_IDLE;
         end
      endcase
      if (mr_sync_r) begin
         seq_nxt = frm_pkg::SEQ_IDLE;
         seq_cnt_nxt = 8'h00;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         seq_r <= frm_pkg::SEQ_IDLE;
         seq_cnt_r <= 8'h00;
      end else if (ce_i) begin
         seq_r <= seq_nxt;
         seq_cnt_r <= seq_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Media sense qualification
   // ----------------------------------------------------------------
   wire media_en = floppy_config_r[frm_pkg::CFG_MEDIA_EN_BIT];
   // Disabled sense reads as no media, whatever the pins show
   wire [1:0] media_q = media_en ? ms_sync_r : 2'h0;
   logic [1:0] media_present_r;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         media_present_r <= 2'h0;
      end else if (ce_i) begin
         media_present_r <= media_q;
      end
   end

   assign media_present_o = media_present_r;

   // ----------------------------------------------------------------
   // Motor encoder
   // ----------------------------------------------------------------
   // Master reset wins over the register value, a same-cycle write included
   frm_motor_if mot ();

   assign mot.motor_on = drive_output_control_reg_r[frm_pkg::MOTOR_LSB +: 4];
   assign mot.drive_sel = drive_output_control_reg_r[frm_pkg::DRV_SEL_LSB +: 2];
   assign mot.four_drive = floppy_config_r[frm_pkg::CFG_FOUR_DRIVE_BIT];
   assign mot.force_off = mr_sync_r;

   frm_motor_enc u_motor_enc (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .mot(mot),
      .motor_enable_n_o(motor_enable_n_o)
   );

   // ----------------------------------------------------------------
   // Read mux and acknowledge
   // ----------------------------------------------------------------
   wire seq_busy = (seq_r == frm_pkg::SEQ_BUSY);
   logic [7:0] status_byte;

   always_comb begin
      status_byte = 8'h00;
      status_byte[frm_pkg::STAT_BUSY_BIT] = seq_busy;
      status_byte[frm_pkg::STAT_RESET_BIT] = mr_sync_r;
      status_byte[frm_pkg::STAT_MEDIA_LSB +: 2] = media_q;
   end
   wire [7:0] rd_byte = sel_drive_out ? drive_output_control_reg_r :
                        sel_data_rate ? data_rate_r :
                        sel_cfg_ctrl ? config_control_reg_r :
                        sel_status ? status_byte :
                        sel_mode ? mode_param_r :
                        sel_setup ? setup_param_r :
                        sel_lock ? lock_param_r :
                        sel_timing ? timing_param_r :
                        sel_fcfg ? floppy_config_r :
                        8'h00;

   logic wb_ack_r;
   logic [31:0] wb_dat_r;

   // Every request, mapped or not, is answered one cycle later; unmapped reads give zero
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_r <= bus_req;
         if (bus_rd) begin
            wb_dat_r <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign wb_ack_o = wb_ack_r;
   assign wb_dat_o = wb_dat_r;

endmodule

// File: src/frm_motor_enc.sv
// Motor enable encoder: two-drive or four-drive form, registered and active low
`timescale 1ns/1ps
module frm_motor_enc (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   frm_motor_if.enc mot,
   output logic [1:0] motor_enable_n_o
);

   logic [1:0] motor_enable_n_r;
   logic [1:0] motor_enable_n_nxt;
   wire sel_on = mot.motor_on[mot.drive_sel];
   wire [1:0] two_drive_n = ~mot.motor_on[1:0];
   // Four drives on two lines: line 0 low means selected drive's motor is on,
   // line 1 low adds that the selected drive is in the upper pair
   wire [1:0] four_drive_n = ~{sel_on & mot.drive_sel[1], sel_on};

   assign motor_enable_n_nxt = mot.force_off ? frm_pkg::MOTOR_OFF_N :
                               (mot.four_drive ? four_drive_n :
                               two_drive_n);

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         motor_enable_n_r <= frm_pkg::MOTOR_OFF_N;
      end else if (ce_i) begin
         motor_enable_n_r <= motor_enable_n_nxt;
      end
   end

   assign motor_enable_n_o = motor_enable_n_r;

endmodule

// File: src/frm_motor_if.sv
// Interface: motor control bits passed from the register core to the motor encoder
`timescale 1ns/1ps
interface frm_motor_if;
   logic [3:0] motor_on;
   logic [1:0] drive_sel;
   logic four_drive;
   logic force_off;

   modport core (output motor_on, output drive_sel, output four_drive, output force_off);
   modport enc (input motor_on, input drive_sel, input four_drive, input force_off);
endinterface

// File: src/frm_pkg.sv
// Package: register map, field positions, reset values and timing for the floppy reset/motor block
package frm_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DRIVE_OUT = 8'h00;
   localparam logic [7:0] ADDR_DATA_RATE = 8'h04;
   localparam logic [7:0] ADDR_CFG_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MODE_PARAM = 8'h10;
   localparam logic [7:0] ADDR_SETUP_PARAM = 8'h14;
   localparam logic [7:0] ADDR_LOCK_PARAM = 8'h18;
   localparam logic [7:0] ADDR_TIMING_PARAM = 8'h1C;
   localparam logic [7:0] ADDR_COMMAND = 8'h20;
   localparam logic [7:0] ADDR_FLOPPY_CONFIG = 8'hF0;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DRV_SEL_LSB = 0;
   localparam int MOTOR_LSB = 4;
   localparam int CFG_MEDIA_EN_BIT = 6;
   localparam int CFG_FOUR_DRIVE_BIT = 7;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RESET_BIT = 1;
   localparam int STAT_MEDIA_LSB = 2;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_MODE_PARAM = 8'h00;
   localparam logic [7:0] RST_SETUP_PARAM = 8'h00;
   localparam logic [7:0] RST_LOCK_PARAM = 8'h00;
   localparam logic [7:0] RST_TIMING_PARAM = 8'h00;
   localparam logic [7:0] RST_FLOPPY_CONFIG = 8'h00;
   localparam logic [1:0] MOTOR_OFF_N = 2'h3;

   // ----------------------------------------------------------------
   // Timing: a started command keeps the sequencer busy this long
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int CMD_TIME_NS = 64;
   localparam int CMD_CYCLES = (CMD_TIME_NS * CLK_MHZ) / 1000;

   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_BUSY = 1'b1
   } frm_seq_t;

endpackage
